// >>> rtl/mox_exec.sv
// Execute stage for OR-with-file, move-file, literal load, store and no-op.
// Assumes file data is read combinationally from the addressed register.
`timescale 1ns/1ps
module mox_exec
   import mox_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Instruction
   input wire logic insn_valid,
   input wire logic [13:0] insn,
   // File register port
   output logic [6:0] file_addr,
   input wire logic [7:0] file_rdata,
   output logic [7:0] file_wdata,
   output logic file_we,
   // Core state
   output logic [7:0] work,
   output logic zero_flag,
   output logic zero_we
);
   mox_dec_if dif();
   logic [7:0] work_q;
   logic zero_q;
   logic [7:0] result;
   logic to_file;
   logic sets_z;
   logic writes_w;

   mox_decode u_dec (
      .dif(dif)
   );

   assign dif.insn = insn;
   assign file_addr = dif.addr;

   // ----------------------------------------
   // Result and write steering
   // ----------------------------------------
   // File write is combinational so it lands in the same instruction cycle.
   always_comb begin
      result = 8'h00;
      to_file = 1'b0;
      sets_z = 1'b0;
      writes_w = 1'b0;
      if (insn_valid) begin
         case (dif.op)
            MOX_OR: begin
               result = work_q | file_rdata;
               to_file = dif.dest_file;
               writes_w = !dif.dest_file;
               sets_z = 1'b1;
            end
            MOX_MOVE: begin
               result = file_rdata;
               to_file = dif.dest_file;
               writes_w = !dif.dest_file;
               sets_z = 1'b1;
            end
            MOX_LIT: begin
               result = dif.literal;
               writes_w = 1'b1;
            end
            MOX_STORE: begin
               result = work_q;
               to_file = 1'b1;
            end
            MOX_NOP: begin
               result = 8'h00;
            end
            default: begin
               result = 8'h00;
            end
         endcase
      end
   end

   assign file_we = to_file;
   assign file_wdata = result;
   assign zero_we = sets_z;

   // ----------------------------------------
   // Working register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         work_q <= WORK_RESET;
      end else if (writes_w) begin
         work_q <= result;
      end
   end

   // ----------------------------------------
   // Zero flag
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         zero_q <= ZERO_RESET;
      end else if (sets_z) begin
         zero_q <= (result == 8'h00);
      end
   end

   assign work = work_q;
   assign zero_flag = zero_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_lit;
      insn_valid && insn[13:10] == 4'hC;
   endsequence

   // ----------------------------------------
   // Step sequences
   // ----------------------------------------
   // Patterns spelled out here so a decode slip cannot hide behind the decoder's output
   sequence s_or_to_file;
      insn_valid && insn[13:8] == 6'h04 && insn[7];
   endsequence

   sequence s_move_to_file;
      insn_valid && insn[13:8] == 6'h08 && insn[7];
   endsequence

   sequence s_file_op;
      insn_valid && (insn[13:8] == 6'h04 || insn[13:8] == 6'h08);
   endsequence

   sequence s_store_op;
      insn_valid && insn[13:7] == 7'h01;
   endsequence

   sequence s_foreign;
      insn_valid && insn[13:12] == 2'h3 && insn[11:10] != 2'h0;
   endsequence

   property p_or_work;
      @(posedge core_clk) disable iff (!reset_n)
      (insn_valid && insn[13:8] == 6'h04 && !insn[7])
         |=> work == ($past(work) | $past(file_rdata)) && zero_flag == (work == 8'h00);
   endproperty
   a_or_work: assert property (p_or_work) else $error("or to work wrong");

   property p_or_file;
      @(posedge core_clk) disable iff (!reset_n)
      (insn_valid && insn[13:8] == 6'h04 && insn[7])
         |-> file_we && file_wdata == (work | file_rdata) ##1 $stable(work);
   endproperty
   a_or_file: assert property (p_or_file) else $error("or to file wrong");

   property p_move;
      @(posedge core_clk) disable iff (!reset_n)
      (insn_valid && insn[13:8] == 6'h08 && !insn[7])
         |=> work == $past(file_rdata) && zero_flag == ($past(file_rdata) == 8'h00);
   endproperty
   a_move: assert property (p_move) else $error("move to work wrong");

   property p_lit;
      @(posedge core_clk) disable iff (!reset_n)
      s_lit |=> work == $past(insn[7:0]) && $stable(zero_flag);
   endproperty
   a_lit: assert property (p_lit) else $error("literal load wrong");

   property p_lit_nowrite;
      @(posedge core_clk) disable iff (!reset_n)
      s_lit |-> !file_we && !zero_we;
   endproperty
   a_lit_nowrite: assert property (p_lit_nowrite) else $error("literal side effect");

   property p_store;
      @(posedge core_clk) disable iff (!reset_n)
      (insn_valid && insn[13:7] == 7'h01)
         |-> file_we && file_wdata == work && !zero_we ##1 $stable(zero_flag);
   endproperty
   a_store: assert property (p_store) else $error("store wrong");

   property p_nop;
      @(posedge core_clk) disable iff (!reset_n)
      (insn_valid && insn[13:7] == 7'h00 && insn[4:0] == 5'h00)
         |-> !file_we ##1 $stable(work) && $stable(zero_flag);
   endproperty
   a_nop: assert property (p_nop) else $error("nop changed state");

   property p_addr;
      @(posedge core_clk) disable iff (!reset_n)
      insn_valid |-> file_addr == insn[6:0];
   endproperty
   a_addr: assert property (p_addr) else $error("address field wrong");

   property p_or_file_zero;
      @(posedge core_clk) disable iff (!reset_n)
      s_or_to_file |=> $stable(work)
         && zero_flag == (($past(work) | $past(file_rdata)) == 8'h00);
   endproperty
   a_or_file_zero: assert property (p_or_file_zero) else $error("or to file zero wrong");

   property p_move_file;
      @(posedge core_clk) disable iff (!reset_n)
      s_move_to_file |-> file_we && file_wdata == file_rdata && zero_we
         ##1 $stable(work) && zero_flag == ($past(file_rdata) == 8'h00);
   endproperty
   a_move_file: assert property (p_move_file) else $error("move to file wrong");

   property p_dest;
      @(posedge core_clk) disable iff (!reset_n)
      s_file_op |-> file_we == insn[DEST_BIT] && zero_we;
   endproperty
   a_dest: assert property (p_dest) else $error("destination select wrong");

   property p_store_keep;
      @(posedge core_clk) disable iff (!reset_n)
      s_store_op |=> $stable(work);
   endproperty
   a_store_keep: assert property (p_store_keep) else $error("store changed work");

   // Other literal-class words belong to other execute paths and must leave this one idle
   property p_foreign;
      @(posedge core_clk) disable iff (!reset_n)
      s_foreign |-> !file_we && !zero_we ##1 $stable(work) && $stable(zero_flag);
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign opcode acted");
endmodule : mox_exec

// >>> common/mox_pkg.sv
// Constants and types for the move/or/nop instruction execute block.
// Assumes a 14-bit instruction word presented once per instruction cycle.
// Contract
// - OR work with file, dest bit picks target, Z
// - Literal loads work, flags unchanged, one cycle
// - Literal decode ignores the two don't-care bits
// - Store work into file, flags unchanged
// - No-operation changes nothing, one cycle
package mox_pkg;
   // ----------------------------------------
   // Instruction fields
   // ----------------------------------------
   localparam int INSN_W = 14;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int DEST_BIT = 7;
   localparam int ADDR_LSB = 0;
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [5:0] OP_MOVE_FILE = 6'h08;
   localparam logic [5:0] OP_ZERO = 6'h00;
   localparam logic [3:0] OP_LIT_HI = 4'hC;
   localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;

   typedef enum logic [5:0] {
      MOX_NOP = 6'h01,
      MOX_OR = 6'h02,
      MOX_MOVE = 6'h04,
      MOX_LIT = 6'h08,
      MOX_STORE = 6'h10,
      MOX_OTHER = 6'h20
   } mox_op_t;
endpackage : mox_pkg

// >>> common/mox_dec_if.sv
// Carrier between the execute top and its decoder.
// Assumes both ends sit on core_clk.
`timescale 1ns/1ps
interface mox_dec_if;
   logic [13:0] insn;
   mox_pkg::mox_op_t op;
   logic dest_file;
   logic [6:0] addr;
   logic [7:0] literal;
   modport dec (input insn, output op, dest_file, addr, literal);
   modport exe (output insn, input op, dest_file, addr, literal);
endinterface : mox_dec_if

// >>> rtl/mox_decode.sv
// Combinational opcode decode for the execute block.
// Assumes a stable instruction word within the cycle.
`timescale 1ns/1ps
module mox_decode
   import mox_pkg::*;
(
   // Decode carrier
   mox_dec_if.dec dif
);
   function automatic mox_op_t classify(input logic [INSN_W-1:0] w);
      mox_op_t r;
      r = MOX_OTHER;
      if (w[13:10] == OP_LIT_HI) begin
         r = MOX_LIT;
      end else if (w[13:8] == OP_OR_FILE) begin
         r = MOX_OR;
      end else if (w[13:8] == OP_MOVE_FILE) begin
         r = MOX_MOVE;
      end else if (w[13:8] == OP_ZERO && w[7]) begin
         r = MOX_STORE;
      end else if (w[13:8] == OP_ZERO && w[4:0] == 5'h00) begin
         r = MOX_NOP;
      end
      return r;
   endfunction : classify

   assign dif.op = classify(dif.insn);
   assign dif.dest_file = dif.insn[DEST_BIT];
   assign dif.addr = dif.insn[ADDR_LSB +: ADDR_W];
   assign dif.literal = dif.insn[DATA_W-1:0];
endmodule : mox_decode

// >>> verification/mox_exec_test.sv
// Self-checking bench for the move/or/nop execute block.
// Assumes the bench plays the file register port by presenting read data per step.
`timescale 1ns/1ps
module mox_exec_test;
   import mox_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic insn_valid = 1'b0;
   logic [13:0] insn = 14'h0000;
   logic [7:0] file_rdata = 8'h00;
   logic [6:0] file_addr;
   logic [7:0] file_wdata, work;
   logic file_we, zero_flag, zero_we;
   int fail_count = 0;
   int checked = 0;

   always #5 core_clk = ~core_clk;

   mox_exec i_mox_exec (.core_clk(core_clk), .reset_n(reset_n), .insn_valid(insn_valid),
      .insn(insn), .file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata),
      .file_we(file_we), .work(work), .zero_flag(zero_flag), .zero_we(zero_we));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task finish_test;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Comb outputs are judged 2 ns after the launching edge, once they settle
   task step(input logic [13:0] i, input logic [7:0] rd, input logic we,
             input logic [7:0] wd, input logic zwe);
      @(posedge core_clk);
      insn_valid <= 1'b1;
      insn <= i;
      file_rdata <= rd;
      #2;
      cmp({1'b0, file_addr}, {1'b0, i[6:0]});
      cmp({7'h00, file_we}, {7'h00, we});
      cmp({7'h00, zero_we}, {7'h00, zwe});
      if (we)
         cmp(file_wdata, wd);
   endtask : step

   task settle(input logic [7:0] w, input logic z);
      @(posedge core_clk);
      insn_valid <= 1'b0;
      #2;
      cmp(work, w);
      cmp({7'h00, zero_flag}, {7'h00, z});
   endtask : settle

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_or;
      step(14'h3091, 8'h00, 1'b0, 8'h00, 1'b0);
      step(14'h0413, 8'h13, 1'b0, 8'h00, 1'b1);
      settle(8'h93, 1'b0);
      step(14'h0493, 8'h0C, 1'b1, 8'h9F, 1'b1);
      settle(8'h93, 1'b0);
      step(14'h3000, 8'h00, 1'b0, 8'h00, 1'b0);
      step(14'h0400, 8'h00, 1'b0, 8'h00, 1'b1);
      settle(8'h00, 1'b1);
   endtask : t_or

   task t_move;
      step(14'h08FF, 8'h5A, 1'b1, 8'h5A, 1'b1);
      settle(8'h00, 1'b0);
      step(14'h0805, 8'hC3, 1'b0, 8'h00, 1'b1);
      settle(8'hC3, 1'b0);
      step(14'h087F, 8'h00, 1'b0, 8'h00, 1'b1);
      settle(8'h00, 1'b1);
   endtask : t_move

   // Zero is left set so a stray flag write by the literal load shows
   task t_lit;
      logic [1:0] dc;
      for (int d = 0; d < 4; d++) begin
         dc = d[1:0];
         step({4'hC, dc, 6'h28, dc}, 8'hFF, 1'b0, 8'h00, 1'b0);
         settle({6'h28, dc}, 1'b1);
      end
   endtask : t_lit

   task t_store;
      step(14'h00FF, 8'h00, 1'b1, 8'hA3, 1'b0);
      settle(8'hA3, 1'b1);
      step(14'h0080, 8'h55, 1'b1, 8'hA3, 1'b0);
      settle(8'hA3, 1'b1);
   endtask : t_store

   task t_nop;
      logic [1:0] dc;
      for (int d = 0; d < 4; d++) begin
         dc = d[1:0];
         step({7'h00, dc, 5'h00}, 8'h00, 1'b0, 8'h00, 1'b0);
         settle(8'hA3, 1'b1);
      end
   endtask : t_nop

   // Words outside this block's opcodes must leave both write enables off and work and zero unchanged
   task t_other;
      step(14'h3835, 8'h00, 1'b0, 8'h00, 1'b0);
      settle(8'hA3, 1'b1);
      step(14'h0062, 8'h00, 1'b0, 8'h00, 1'b0);
      settle(8'hA3, 1'b1);
   endtask : t_other

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      settle(8'h00, 1'b0);
      t_or();
      t_move();
      t_lit();
      t_store();
      t_nop();
      t_other();
      finish_test();
   end

   // The run needs well under 100 cycles; 10000 leaves a wide margin
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule : mox_exec_test
